// ---- rtl/wdpr_core.sv ----
// watchdog, power management and reset control of the microcontroller
//
// Strobed register access was left to the implementer.
`timescale 1ns/1ps
`include "wdpr_params.svh"
module wdpr_core #(
  parameter int WDOG_BITS = `WDPR_WDOG_BITS,
  parameter int FIXED_DIV = `WDPR_FIXED_DIV
) (
  input  wire logic       clk_sys,
  input  wire logic       rst,
  input  wire logic       ce,
  input  wire logic       ext_reset,
  input  wire logic       power_on,
  input  wire logic       irq_pending,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  output logic            osc_run,
  output logic            periph_clk_en,
  output logic            cpu_clk_en,
  output logic            system_reset,
  output logic            wdog_timeout,
  output logic      [7:0] port_reset_value,
  output logic      [7:0] stack_reset_value
);
  // ==========================================
  // state
  wdpr_pkg::wdpr_mode_t         mode;
  logic                         half_phase;
  logic [3:0]                   fixed_count;
  logic [2:0]                   state_count;
  logic                         machine_tick;
  logic                         fixed_tick;
  logic                         pre_tick;
  logic [WDOG_BITS-1:0]         wdog_count;
  logic                         wdog_enable;
  logic                         wdog_clear;
  logic                         wdog_run_in_idle;
  logic [2:0]                   prescale_sel;
  logic [3:0]                   power_flags;
  logic                         cold_boot_flag;
  logic [1:0]                   reset_hist;
  logic                         reset_sample;
  logic                         sys_reset_q;
  logic                         timeout_seen;
  logic                         wdog_run;
  logic                         clock_live;
  logic                         internal_rst;
  logic [WDOG_BITS+7:0]         status_word;

  assign internal_rst = sys_reset_q;
  // a short counter is padded below, so its top bits still read in the top of status
  assign status_word = {wdog_count, 8'h00};
  // power-down freezes everything but the reset path, the power control register and mode, the cold boot flag and the register read port
  assign clock_live = ce && (mode != wdpr_pkg::WDPR_POWERDOWN);

  // ==========================================
  // internal clock halving and machine cycle
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      half_phase <= 1'b0;
    end else if (clock_live) begin
      half_phase <= ~half_phase;
    end
  end

  // one state per two oscillator periods, six states per machine cycle
  assign machine_tick = half_phase && (state_count == 3'(`WDPR_STATES_PER_CYCLE - 1));

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_count <= 3'h0;
    end else if (clock_live && half_phase) begin
      state_count <= machine_tick ? 3'h0 : state_count + 3'h1;
    end
  end

  // ==========================================
  // fixed divide by twelve of the oscillator
  assign fixed_tick = (fixed_count == 4'(FIXED_DIV - 1));

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      fixed_count <= 4'h0;
    end else if (clock_live) begin
      if (internal_rst || wdog_clear) begin
        fixed_count <= 4'h0;
      end else if (wdog_run) begin
        fixed_count <= fixed_tick ? 4'h0 : fixed_count + 4'h1;
      end
    end
  end

  // ==========================================
  // watchdog run condition
  always_comb begin
    wdog_run = wdog_enable && !internal_rst;
    if (mode == wdpr_pkg::WDPR_IDLE && !wdog_run_in_idle) begin
      wdog_run = 1'b0;
    end
  end

  wdpr_prescaler u_prescaler (
    .clk_sys  (clk_sys),
    .rst      (rst),
    .ce       (clock_live),
    .clear    (wdog_clear || internal_rst),
    .tick_in  (wdog_run && fixed_tick),
    .sel      (prescale_sel),
    .tick_out (pre_tick)
  );

  // ==========================================
  // watchdog counter
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wdog_count   <= '0;
      timeout_seen <= 1'b0;
    end else if (clock_live) begin
      timeout_seen <= 1'b0;
      if (internal_rst) begin
        wdog_count <= '0;
      end else if (wdog_clear) begin
        wdog_count <= '0;
      end else if (wdog_run && pre_tick) begin
        wdog_count <= wdog_count + 1'b1;
        if (&wdog_count) begin
          timeout_seen <= 1'b1;
        end
      end
    end
  end

  assign wdog_timeout = timeout_seen;

  // ==========================================
  // watchdog control register
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wdog_enable      <= 1'b0;
      wdog_clear       <= 1'b0;
      wdog_run_in_idle <= 1'b0;
      prescale_sel     <= 3'h0;
    end else if (clock_live) begin
      if (internal_rst) begin
        wdog_enable      <= 1'b0;
        wdog_clear       <= 1'b0;
        wdog_run_in_idle <= 1'b0;
        prescale_sel     <= 3'h0;
      end else if (reg_wr && reg_addr == `WDPR_OFF_WATCHDOG_CONTROL) begin
        wdog_enable      <= reg_wdata[`WDPR_BIT_WDOG_ENABLE];
        wdog_clear       <= reg_wdata[`WDPR_BIT_WDOG_CLEAR];
        wdog_run_in_idle <= reg_wdata[`WDPR_BIT_WDOG_RUN_IN_IDLE];
        prescale_sel     <= reg_wdata[2:0];
      end else begin
        // self clearing one cycle after the write
        wdog_clear <= 1'b0;
      end
    end
  end

  // ==========================================
  // power control register and mode
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      power_flags <= 4'h0;
      mode        <= wdpr_pkg::WDPR_RUN;
    end else if (ce) begin
      if (internal_rst) begin
        power_flags <= 4'h0;
        mode        <= wdpr_pkg::WDPR_RUN;
      end else begin
        unique case (mode)
          wdpr_pkg::WDPR_RUN: begin
            if (reg_wr && reg_addr == `WDPR_OFF_POWER_CONTROL) begin
              power_flags <= reg_wdata[3:0];
              if (reg_wdata[`WDPR_BIT_POWERDOWN]) begin
                mode <= wdpr_pkg::WDPR_POWERDOWN;
              end else if (reg_wdata[`WDPR_BIT_IDLE]) begin
                mode <= wdpr_pkg::WDPR_IDLE;
              end
            end
          end
          wdpr_pkg::WDPR_IDLE: begin
            if (irq_pending) begin
              mode                      <= wdpr_pkg::WDPR_RUN;
              power_flags[`WDPR_BIT_IDLE] <= 1'b0;
            end
          end
          wdpr_pkg::WDPR_POWERDOWN: begin
            mode <= wdpr_pkg::WDPR_POWERDOWN;
          end
          default: begin
            mode <= wdpr_pkg::WDPR_RUN;
          end
        endcase
      end
    end
  end

  // cold boot flag survives warm resets; set on power-up, cleared by software
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cold_boot_flag <= 1'b0;
    end else if (ce) begin
      if (power_on) begin
        cold_boot_flag <= 1'b1;
      end else if (reg_wr && reg_addr == `WDPR_OFF_POWER_CONTROL && !internal_rst) begin
        cold_boot_flag <= reg_wdata[`WDPR_BIT_COLD_BOOT];
      end
    end
  end

  // ==========================================
  // reset sampling and deglitch
  // the pin is read at one fixed state of each machine cycle; the oscillator
  // must run, except that in power-down the pin is watched every cycle
  assign reset_sample = (mode == wdpr_pkg::WDPR_POWERDOWN) ? 1'b1 :
                        (machine_tick == 1'b0 && half_phase &&
                         state_count == 3'(`WDPR_SAMPLE_STATE));

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      reset_hist  <= 2'h0;
      sys_reset_q <= 1'b1;
    end else if (ce) begin
      if (reset_sample) begin
        reset_hist <= {reset_hist[0], ext_reset};
      end
      // two consecutive high samples needed, so a glitch is never taken
      if (timeout_seen) begin
        sys_reset_q <= 1'b1;
      end else if (reset_sample) begin
        sys_reset_q <= reset_hist[0] && ext_reset;
      end
    end
  end

  assign system_reset = sys_reset_q;

  // ==========================================
  // clock gates
  assign osc_run       = (mode != wdpr_pkg::WDPR_POWERDOWN);
  assign periph_clk_en = osc_run && half_phase;
  assign cpu_clk_en    = periph_clk_en && (mode == wdpr_pkg::WDPR_RUN) && !sys_reset_q;

  assign port_reset_value  = `WDPR_RST_PORT;
  assign stack_reset_value = `WDPR_RST_STACK_POINTER;

  // ==========================================
  // register read port
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (ce) begin
      reg_rdata <= 8'h00;
      if (reg_rd) begin
        unique case (reg_addr)
          `WDPR_OFF_WATCHDOG_CONTROL:
            reg_rdata <= {wdog_enable, wdog_clear, wdog_run_in_idle, 2'b00, prescale_sel};
          `WDPR_OFF_POWER_CONTROL:
            reg_rdata <= {3'b000, cold_boot_flag, power_flags};
          `WDPR_OFF_WDOG_STATUS:
            reg_rdata <= status_word[WDOG_BITS+7 -: 8];
          default:
            reg_rdata <= 8'h00;
        endcase
      end
    end
  end
endmodule

// ---- inc/wdpr_params.svh ----
// constants of the watchdog, power and reset control block
`ifndef WDPR_PARAMS_SVH
`define WDPR_PARAMS_SVH
// ==========================================
// register offsets
`define WDPR_OFF_WATCHDOG_CONTROL 8'h8f
`define WDPR_OFF_POWER_CONTROL    8'h87
`define WDPR_OFF_WDOG_STATUS      8'h90
// ==========================================
// field positions
`define WDPR_BIT_WDOG_ENABLE      7
`define WDPR_BIT_WDOG_CLEAR       6
`define WDPR_BIT_WDOG_RUN_IN_IDLE 5
`define WDPR_BIT_COLD_BOOT        4
`define WDPR_BIT_POWERDOWN        1
`define WDPR_BIT_IDLE             0
// ==========================================
// reset values
`define WDPR_RST_WATCHDOG_CONTROL 8'h00
`define WDPR_RST_POWER_CONTROL    8'h00
`define WDPR_RST_PORT             8'hff
`define WDPR_RST_STACK_POINTER    8'h07
// ==========================================
// timing counts
`define WDPR_FIXED_DIV            12
`define WDPR_WDOG_BITS            14
`define WDPR_STATES_PER_CYCLE     6
`define WDPR_SAMPLE_STATE         4
`define WDPR_RESET_HOLD_CYCLES    2
`endif

// ---- inc/wdpr_pkg.sv ----
// types of the watchdog, power and reset control block
package wdpr_pkg;
  typedef enum logic [1:0] {
    WDPR_RUN,
    WDPR_IDLE,
    WDPR_POWERDOWN
  } wdpr_mode_t;
endpackage

// ---- rtl/wdpr_prescaler.sv ----
// selectable watchdog prescaler with non-binary code order
`timescale 1ns/1ps
`include "wdpr_params.svh"
module wdpr_prescaler (
  input  wire logic       clk_sys,
  input  wire logic       rst,
  input  wire logic       ce,
  input  wire logic       clear,
  input  wire logic       tick_in,
  input  wire logic [2:0] sel,
  output logic            tick_out
);
  logic [7:0] count;
  logic [7:0] last;

  // ==========================================
  // ratio decode
  always_comb begin
    unique case (sel)
      3'h0: last = 8'h01;
      3'h2: last = 8'h03;
      3'h1: last = 8'h07;
      3'h3: last = 8'h0f;
      3'h4: last = 8'h1f;
      3'h5: last = 8'h3f;
      3'h6: last = 8'h7f;
      3'h7: last = 8'hff;
    endcase
  end

  assign tick_out = tick_in && (count == last);

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      count <= 8'h00;
    end else if (ce) begin
      if (clear) begin
        count <= 8'h00;
      end else if (tick_in) begin
        // ratio change below the current count restarts from zero at the next input tick
        count <= (count >= last) ? 8'h00 : count + 8'h01;
      end
    end
  end
endmodule

// ---- verification/wdpr_core_asserts.sv ----
// port checker of the watchdog, power and reset block
`timescale 1ns/1ps
module wdpr_core_asserts (
  input wire logic       clk_sys,
  input wire logic       rst,
  input wire logic       ce,
  input wire logic       ext_reset,
  input wire logic       osc_run,
  input wire logic       periph_clk_en,
  input wire logic       cpu_clk_en,
  input wire logic       system_reset,
  input wire logic       wdog_timeout,
  input wire logic [7:0] port_reset_value,
  input wire logic [7:0] stack_reset_value
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  // ==========================================
  // time-out followed by system reset
  sequence s_tmo;
    wdog_timeout ##1 (system_reset && !wdog_timeout);
  endsequence
  a_tmo_reset: assert property (wdog_timeout |-> s_tmo) else $error("timeout without reset");
  a_port_ones: assert property (port_reset_value == 8'hff) else $error("port value");
  a_stack_init: assert property (stack_reset_value == 8'h07) else $error("stack value");
  a_clk_halved: assert property (ce && periph_clk_en |=> !periph_clk_en) else $error("clock not halved");
  a_pd_stops: assert property (!osc_run |-> !periph_clk_en && !cpu_clk_en) else $error("clock in power-down");
  a_cpu_gate: assert property (cpu_clk_en |-> periph_clk_en && !system_reset) else $error("cpu clock gating");
  a_pd_no_tmo: assert property (!osc_run |-> !wdog_timeout) else $error("timeout in power-down");
  // a reset needs a time-out or a pin held across two samples; samples lie 12 clocks
  // apart when running, one clock apart in power-down
  a_rst_cause: assert property ($rose(system_reset) |->
    $past(wdog_timeout) || ($past(ext_reset) && (osc_run ? $past(ext_reset, 13) : $past(ext_reset, 2))))
    else $error("reset without cause");
endmodule
bind wdpr_core wdpr_core_asserts u_chk (.clk_sys, .rst, .ce, .ext_reset, .osc_run, .periph_clk_en, .cpu_clk_en,
  .system_reset, .wdog_timeout, .port_reset_value, .stack_reset_value);

// ---- verification/test_wdpr_core.sv ----
// self-checking bench of the watchdog, power and reset block
`timescale 1ns/1ps
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin n_fail++; $display("BAD %0t got %h exp %h", $time, got, exp); end end
module test_wdpr_core;
  logic       clk_sys, rst, ce, ext_reset, power_on, irq_pending, reg_wr, reg_rd;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, port_reset_value, stack_reset_value, exp_v, d;
  logic       osc_run, periph_clk_en, cpu_clk_en, system_reset, wdog_timeout, v;
  logic       rd_d = 1'b0;
  logic [7:0] expq[$];
  logic [2:0] codes[4] = '{3'b000, 3'b010, 3'b001, 3'b011};
  logic [31:0] seed;
  int         n_fail = 0, checks = 0, n_tmo = 0, cyc = 0, n, t, k, e;
  // short counter keeps every time-out within a few thousand cycles
  wdpr_core #(.WDOG_BITS(4)) u_dut (.clk_sys, .rst, .ce, .ext_reset, .power_on, .irq_pending, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .osc_run, .periph_clk_en, .cpu_clk_en, .system_reset,
    .wdog_timeout, .port_reset_value, .stack_reset_value);
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // ==========================================
  // register port driver, reads note their expectation
  // a strobe drops when a wait or a transfer of the other kind follows, so back-to-back transfers drive each strobe once per step
  task automatic bus_idle();
    if (reg_wr) reg_wr <= 1'b0;
    if (reg_rd) reg_rd <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] wd);
    reg_addr <= a; reg_wdata <= wd; reg_wr <= 1'b1;
    if (reg_rd) reg_rd <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] ex);
    reg_addr <= a; reg_rd <= 1'b1; expq.push_back(ex);
    if (reg_wr) reg_wr <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic ticks(input int c);
    bus_idle();
    repeat (c) @(posedge clk_sys);
  endtask
  task automatic wait_ready();
    bus_idle();
    for (int i = 0; i < 300 && system_reset !== 1'b0; i++) @(posedge clk_sys);
    `CHK(system_reset, 1'b0)
  endtask
  task automatic wait_cpu();
    bus_idle();
    for (int i = 0; i < 12 && cpu_clk_en !== 1'b1; i++) @(posedge clk_sys);
    `CHK(cpu_clk_en, 1'b1)
  endtask
  task automatic tmo_wait(input int lim);
    bus_idle();
    t = n_tmo; n = 0;
    while (n_tmo == t && n < lim) begin @(posedge clk_sys); n++; end
  endtask
  task automatic finish_test();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // ==========================================
  // output watcher
  always @(posedge clk_sys) begin
    rd_d <= reg_rd;
    if (wdog_timeout === 1'b1) n_tmo <= n_tmo + 1;
    if (rd_d === 1'b1) begin
      exp_v = expq.pop_front();
      `CHK(reg_rdata, exp_v)
    end
    cyc++;
    if (cyc == 30000) begin n_fail++; finish_test(); end
  end
  // ==========================================
  // scenarios
  initial begin
    rst = 1'b1; ce = 1'b1; ext_reset = 1'b0; power_on = 1'b1; irq_pending = 1'b0;
    reg_addr = 8'h00; reg_wdata = 8'h00; reg_wr = 1'b0; reg_rd = 1'b0; seed = 32'h77ac43be;
    ticks(16);
    rst <= 1'b0;
    wait_ready();
    rd(8'h8f, 8'h00);
    rd(8'h87, 8'h10);
    `CHK(port_reset_value, 8'hff)
    `CHK(stack_reset_value, 8'h07)
    wr(8'h55, 8'hff); rd(8'h55, 8'h00); rd(8'h8f, 8'h00); rd(8'h90, 8'h00);
    power_on <= 1'b0;
    wr(8'h8f, 8'h25); wr(8'h8f, 8'h65); ticks(1); rd(8'h8f, 8'h25);
    ticks(600); `CHK(n_tmo, 0)
    for (k = 0; k < 4; k++) begin
      wr(8'h8f, {5'b11000, codes[k]}); tmo_wait(5000); e = 12 * (2 << k) * 16;
      `CHK(n >= e - 16 && n <= e + 16, 1'b1)
      wait_ready(); rd(8'h8f, 8'h00);
    end
    // kicks every 250 cycles against a 384 cycle interval
    wr(8'h8f, 8'h80); t = n_tmo;
    repeat (6) begin ticks(250); wr(8'h8f, 8'hc0); end
    `CHK(n_tmo, t)
    wr(8'h8f, 8'hc0); wr(8'h87, 8'h01); t = n_tmo; ticks(3);
    `CHK(cpu_clk_en, 1'b0)
    v = periph_clk_en; ticks(1); `CHK(v ^ periph_clk_en, 1'b1)
    ticks(600); `CHK(n_tmo, t)
    irq_pending <= 1'b1; wait_cpu(); irq_pending <= 1'b0;
    wr(8'h8f, 8'he0); wr(8'h87, 8'h01); tmo_wait(500);
    `CHK(n < 500, 1'b1)
    wait_ready(); wait_cpu();
    // bit 4 written high so the later read shows it kept across the reset
    wr(8'h8f, 8'hc0); wr(8'h87, 8'h12); t = n_tmo; ticks(2);
    `CHK(osc_run, 1'b0)
    irq_pending <= 1'b1; ticks(600); irq_pending <= 1'b0;
    `CHK(osc_run, 1'b0)
    `CHK(n_tmo, t)
    ext_reset <= 1'b1; ticks(80); ext_reset <= 1'b0;
    wait_ready(); `CHK(osc_run, 1'b1)
    rd(8'h8f, 8'h00); rd(8'h87, 8'h10);
    // at most 12 high cycles, so the pulse never spans two samples 12 clocks apart
    wr(8'h8f, 8'h25); ext_reset <= 1'b1; ticks(1 + xs() % 12); ext_reset <= 1'b0; v = 1'b0;
    repeat (100) begin @(posedge clk_sys); v = v | system_reset; end
    `CHK(v, 1'b0)
    d = xs() & 8'h27; wr(8'h8f, d); rd(8'h8f, d);
    // enable low freezes the halved clock; an odd count of edges would show a toggle
    ce <= 1'b0; ticks(1); v = periph_clk_en; ticks(7);
    `CHK(periph_clk_en, v)
    ce <= 1'b1;
    ticks(4);
    finish_test();
  end
endmodule
